// >>> shared/bwe_pkg.sv
package bwe_pkg;

    // serial command opcodes
    localparam logic [7:0] OP_GENERIC_RD = 8'h65;
    localparam logic [7:0] OP_GENERIC_WR = 8'h71;
    localparam logic [7:0] OP_SET_BURST = 8'hC0;
    localparam logic [7:0] OP_ECC_RD_A = 8'h18;
    localparam logic [7:0] OP_ECC_RD_B = 8'h19;

    // register addresses seen by the generic read and write commands
    localparam logic [23:0] ADDR_BOOT_CFG = 24'h000005;
    localparam logic [23:0] ADDR_LIVE_CFG = 24'h800005;

    // frame field lengths, expressed as last bit index of the counter
    localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;

    // positions of the pins inside the synchroniser bundle
    localparam int PIN_SCK = 2;
    localparam int PIN_CS_N = 1;
    localparam int PIN_SI = 0;
    localparam int PIN_COUNT = 3;

    // layout shared by the boot and live configuration registers
    typedef struct packed {
        logic [2:0] drive_strength;
        logic wrap_disable;
        logic [1:0] reserved;
        logic [1:0] wrap_length;
    } bwe_cfg_t;

    // factory value: drive code 000, sequential reads, 8-byte length
    localparam bwe_cfg_t CFG_FACTORY = '{
        drive_strength: 3'h0,
        wrap_disable: 1'h1,
        reserved: 2'h0,
        wrap_length: 2'h0
    };

    // flags reported by the correction engine for one unit
    typedef struct packed {
        logic check_code_error_flag;
        logic unit_data_error_flag;
        logic correction_off_flag;
    } bwe_ecc_flags_t;

    // correction unit status byte
    typedef struct packed {
        logic [4:0] reserved;
        bwe_ecc_flags_t flags;
    } bwe_ecc_t;

    localparam bwe_ecc_t ECC_RESET = 8'h00;
    localparam logic [4:0] ECC_RSVD_FILL = 5'h00;
    localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // serial frame phases, gray coded along cmd-addr-data-done
    typedef enum logic [2:0] {
        ST_CMD = 3'h0,
        ST_ADDR = 3'h1,
        ST_DIN = 3'h3,
        ST_DOUT = 3'h5,
        ST_DONE = 3'h7
    } bwe_state_t;

endpackage

// >>> src/bwe_sync2.sv
`timescale 1ns/100ps
// two-stage synchroniser for a bundle of asynchronous levels
module bwe_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

// >>> src/bwe_regs.sv
`timescale 1ns/100ps
module bwe_regs
    import bwe_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic por_n_in,
    input wire logic soft_reset_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    input wire logic quad_read_in,
    input wire bwe_ecc_flags_t ecc_flags_in,
    output logic [23:0] ecc_unit_addr_out,
    output logic ecc_req_out,
    output logic [2:0] live_drive_strength_out,
    output logic [1:0] live_wrap_length_out,
    output logic [6:0] wrap_bytes_out,
    output logic wrap_active_out,
    output logic [7:0] correction_unit_status_out
);
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pins_sync;
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic sck_prev_reg;
    logic sck_rise;
    logic sck_fall;
    bwe_state_t state_reg;
    bwe_state_t state_next;
    logic [4:0] cnt_reg;
    logic cnt_last;
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic [7:0] out_sr_reg;
    logic so_reg;
    logic so_oe_reg;
    logic op_has_addr;
    logic op_is_ecc;
    logic op_is_write;
    logic cmd_done;
    logic addr_done;
    logic din_done;
    logic wr_live;
    logic wr_boot;
    logic [7:0] reg_rd_byte;
    logic load_pending_reg;
    bwe_cfg_t boot_wrap_drive_config_reg;
    bwe_cfg_t live_wrap_drive_config_reg;
    bwe_cfg_t din_cfg;
    bwe_ecc_t correction_unit_status_reg;
    bwe_ecc_t ecc_next;
    logic ecc_req_reg;
    logic [23:0] ecc_unit_addr_reg;

    // select crosses inverted, so a synchroniser in reset reads deselected
    assign pins_raw = {sck_in, ~cs_n_in, si_in};

    bwe_sync2 #(
        .WIDTH(PIN_COUNT)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign sck_s = pins_sync[PIN_SCK];
    assign cs_n_s = ~pins_sync[PIN_CS_N];
    assign si_s = pins_sync[PIN_SI];

    // serial clock edges, found on the synchronised copy
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_prev_reg <= 1'h0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_reg & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_reg & ~cs_n_s;

    // frame decode
    assign shift_next = {shift_reg[22:0], si_s};
    assign cnt_last = (state_reg == ST_ADDR) ? (cnt_reg == CNT_ADDR_LAST)
                                             : (cnt_reg == CNT_BYTE_LAST);
    assign op_is_ecc = (op_reg == OP_ECC_RD_A) || (op_reg == OP_ECC_RD_B);
    assign op_is_write = (op_reg == OP_GENERIC_WR);
    assign op_has_addr = (shift_next[7:0] == OP_GENERIC_RD)
        || (shift_next[7:0] == OP_GENERIC_WR)
        || (shift_next[7:0] == OP_ECC_RD_A)
        || (shift_next[7:0] == OP_ECC_RD_B);
    assign cmd_done = sck_rise && (state_reg == ST_CMD) && cnt_last;
    assign addr_done = sck_rise && (state_reg == ST_ADDR) && cnt_last;
    assign din_done = sck_rise && (state_reg == ST_DIN) && cnt_last;
    assign din_cfg = shift_next[7:0];

    assign wr_live = din_done && ((op_reg == OP_SET_BURST)
        || (op_is_write && (addr_reg == ADDR_LIVE_CFG)));
    assign wr_boot = din_done && op_is_write && (addr_reg == ADDR_BOOT_CFG);

    assign reg_rd_byte =
        (shift_next == ADDR_BOOT_CFG) ? boot_wrap_drive_config_reg :
        (shift_next == ADDR_LIVE_CFG) ? live_wrap_drive_config_reg :
        RD_UNMAPPED;

    // next phase of the serial frame; unknown opcodes idle until deselect
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_CMD: begin
                if (cmd_done) begin
                    if (op_has_addr) begin
                        state_next = ST_ADDR;
                    end else if (shift_next[7:0] == OP_SET_BURST) begin
                        state_next = ST_DIN;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_ADDR: begin
                if (addr_done) begin
                    state_next = op_is_write ? ST_DIN : ST_DOUT;
                end
            end
            ST_DIN: begin
                if (din_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DOUT: state_next = ST_DOUT;
            ST_DONE: state_next = ST_DONE;
            default: state_next = ST_CMD;
        endcase
    end

    // frame sequencing; deselect aborts any frame in flight
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_CMD;
            cnt_reg <= CNT_ZERO;
        end else if (cs_n_s) begin
            state_reg <= ST_CMD;
            cnt_reg <= CNT_ZERO;
        end else if (sck_rise) begin
            state_reg <= state_next;
            cnt_reg <= cnt_last ? CNT_ZERO : 5'(cnt_reg + CNT_ONE);
        end
    end

    // input shifting, opcode and address capture on rising sck
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_reg <= '0;
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
        end else if (sck_rise) begin
            shift_reg <= cnt_last ? 24'h000000 : shift_next;
            if (cmd_done) begin
                op_reg <= shift_next[7:0];
            end
            if (addr_done) begin
                addr_reg <= shift_next;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ecc_req_reg <= 1'h0;
            ecc_unit_addr_reg <= 24'h000000;
        end else begin
            ecc_req_reg <= addr_done && op_is_ecc;
            if (addr_done && op_is_ecc) begin
                ecc_unit_addr_reg <= shift_next;
            end
        end
    end

    assign ecc_next = {ECC_RSVD_FILL, ecc_flags_in};

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            correction_unit_status_reg <= ECC_RESET;
        end else if (ecc_req_reg) begin
            correction_unit_status_reg <= ecc_next;
        end
    end

    // output byte: loaded at end of address, shifted msb first on falling
    // sck; it rotates so a long read repeats the same byte
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_sr_reg <= 8'h00;
            so_reg <= 1'h0;
            so_oe_reg <= 1'h0;
        end else if (cs_n_s) begin
            so_oe_reg <= 1'h0;
        end else if (addr_done && !op_is_write && !op_is_ecc) begin
            out_sr_reg <= reg_rd_byte;
        end else if (ecc_req_reg) begin
            out_sr_reg <= ecc_next;
        end else if (sck_fall && (state_reg == ST_DOUT)) begin
            so_reg <= out_sr_reg[7];
            so_oe_reg <= 1'h1;
            out_sr_reg <= {out_sr_reg[6:0], out_sr_reg[7]};
        end
    end

    // non-volatile copy, kept across hardware and software resets
    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            boot_wrap_drive_config_reg <= CFG_FACTORY;
        end else if (wr_boot) begin
            boot_wrap_drive_config_reg <= din_cfg;
        end
    end

    // a pending load survives until one clock after reset or soft reset
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            load_pending_reg <= 1'h1;
        end else begin
            load_pending_reg <= soft_reset_in;
        end
    end

    // reset copy wins over a write landing in the same cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            live_wrap_drive_config_reg <= CFG_FACTORY;
        end else if (load_pending_reg) begin
            live_wrap_drive_config_reg <= boot_wrap_drive_config_reg;
        end else if (wr_live) begin
            live_wrap_drive_config_reg <= din_cfg;
        end
    end

    assign live_drive_strength_out = live_wrap_drive_config_reg.drive_strength;
    assign live_wrap_length_out = live_wrap_drive_config_reg.wrap_length;
    assign wrap_bytes_out = WRAP_BASE_BYTES << live_wrap_length_out;
    assign wrap_active_out = quad_read_in
        && !live_wrap_drive_config_reg.wrap_disable;

    assign so_out = so_reg;
    assign so_oe_out = so_oe_reg;
    assign ecc_req_out = ecc_req_reg;
    assign ecc_unit_addr_out = ecc_unit_addr_reg;
    assign correction_unit_status_out = correction_unit_status_reg;

    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_boot_copy: assert property (
        load_pending_reg |=> live_wrap_drive_config_reg
            == $past(boot_wrap_drive_config_reg))
        else $error("live register not loaded from boot register");
    a_boot_no_effect: assert property (
        wr_boot && !load_pending_reg && !wr_live
            |=> $stable(live_wrap_drive_config_reg))
        else $error("boot write changed live behaviour");
    a_live_write: assert property (
        wr_live && !load_pending_reg
            |=> live_wrap_drive_config_reg == $past(din_cfg))
        else $error("live write not applied");
    a_wrap_gate: assert property (
        wr_live && !load_pending_reg |=> wrap_active_out
            == (quad_read_in && !$past(din_cfg.wrap_disable)))
        else $error("wrap enable mismatch");
    a_wrap_quad_only: assert property (
        !quad_read_in |-> !wrap_active_out)
        else $error("wrap outside quad read");
    a_wrap_bytes: assert property (
        (live_wrap_length_out == 2'h3) |-> (wrap_bytes_out == 7'h40))
        else $error("wrap length decode wrong");
    a_drive_follow: assert property (
        wr_live && !load_pending_reg
            |=> live_drive_strength_out == $past(din_cfg.drive_strength))
        else $error("drive select lags live register");
    a_ecc_capture: assert property (
        addr_done && op_is_ecc |=> ##1
            correction_unit_status_reg.flags == $past(ecc_flags_in))
        else $error("status flags not captured");
    a_ecc_read_only: assert property (
        !ecc_req_reg |=> $stable(correction_unit_status_reg))
        else $error("status changed without a query");
    a_ecc_rsvd: assert property (
        correction_unit_status_reg.reserved == ECC_RSVD_FILL)
        else $error("reserved status bits not zero");
    a_so_idle: assert property (
        cs_n_s |=> !so_oe_out)
        else $error("output driven while deselected");

    c_burst_set: cover property (din_done && (op_reg == OP_SET_BURST));
    c_ecc: cover property (ecc_req_reg && ecc_flags_in.unit_data_error_flag);
    c_boot_wr: cover property (wr_boot);
    c_soft: cover property (soft_reset_in ##1 load_pending_reg);
endmodule

// >>> sim/bwe_host_model.sv
`timescale 1ns/100ps
// serial host, mode 0; link clock rests low between frames
module bwe_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic rd_done_out,
    output logic [7:0] rd_byte_out
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
        rd_done_out = 1'b0;
        rd_byte_out = 8'h00;
    end

    // one bit; si only moves while sck is low, 64 ns link period
    task automatic put_bit(input logic b);
        si_out = b;
        #32 sck_out = 1'b1;
        #32 sck_out = 1'b0;
    endtask

    // opcode, address, write bits, then read bytes
    task automatic frame(input logic [7:0] op, input int na,
                         input logic [23:0] addr, input int nw,
                         input logic [7:0] wd, input int nr);
        logic [7:0] rd;
        cs_n_out = 1'b0;
        #32;
        for (int i = 7; i >= 0; i--) put_bit(op[i]);
        for (int i = 23; i >= 24 - na; i--) put_bit(addr[i]);
        for (int i = 7; i >= 8 - nw; i--) put_bit(wd[i]);
        for (int k = 0; k < nr; k++) begin
            for (int i = 7; i >= 0; i--) begin
                // toggling si so an idle input never looks stable
                si_out = ~si_out;
                #32 sck_out = 1'b1;
                // an undriven so reads as unknown, never as a match
                rd[i] = (so_oe_in === 1'b1) ? so_in : 1'bx;
                #32 sck_out = 1'b0;
            end
            rd_byte_out = rd;
            #1 rd_done_out = 1'b1;
            #1 rd_done_out = 1'b0;
        end
        #32 cs_n_out = 1'b1;
        si_out = ~si_out;
    endtask
endmodule

// >>> sim/tb_burst_wrap_ecc_status_regs.sv
`timescale 1ns/100ps
module tb_burst_wrap_ecc_status_regs;
    import bwe_pkg::*;
    logic ref_clk_in, arst_n_in, por_n_in, soft_reset_in, quad_read_in;
    logic sck, cs_n, si, so_out, so_oe_out, ecc_req_out, wrap_active_out;
    logic rd_done;
    logic [7:0] rd_byte, m;
    bwe_ecc_flags_t ecc_flags_in;
    logic [23:0] ecc_unit_addr_out, a;
    logic [2:0] live_drive_strength_out;
    logic [1:0] live_wrap_length_out;
    logic [6:0] wrap_bytes_out;
    logic [7:0] correction_unit_status_out;
    bwe_cfg_t v, b;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] exp_q[$], mask_q[$];
    logic [23:0] addr_q[$];

    bwe_regs u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .por_n_in(por_n_in), .soft_reset_in(soft_reset_in),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so_out),
        .so_oe_out(so_oe_out), .quad_read_in(quad_read_in),
        .ecc_flags_in(ecc_flags_in), .ecc_unit_addr_out(ecc_unit_addr_out),
        .ecc_req_out(ecc_req_out),
        .live_drive_strength_out(live_drive_strength_out),
        .live_wrap_length_out(live_wrap_length_out),
        .wrap_bytes_out(wrap_bytes_out), .wrap_active_out(wrap_active_out),
        .correction_unit_status_out(correction_unit_status_out));

    bwe_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .so_in(so_out), .so_oe_in(so_oe_out), .rd_done_out(rd_done),
        .rd_byte_out(rd_byte));

    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [23:0] exp,
                         input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // serial read results are matched against the oldest note
    always @(posedge rd_done) begin
        if (exp_q.size() == 0) begin
            failures++;
            $display("[ERR] rd_byte expected none seen %h", rd_byte);
        end else begin
            m = mask_q.pop_front();
            check("rd_byte", {16'h0000, exp_q.pop_front() & m},
                  {16'h0000, rd_byte & m});
        end
    end

    // the unit address offered to the engine must be the one sent
    always @(negedge ref_clk_in) begin
        if (ecc_req_out === 1'b1) begin
            if (addr_q.size() > 0) begin
                check("ecc_unit_addr", addr_q.pop_front(),
                      ecc_unit_addr_out);
            end else begin
                failures++;
                $display("[ERR] ecc_unit_addr expected none seen %h",
                         ecc_unit_addr_out);
            end
        end
    end

    // synchroniser and commit latency fit well inside eight clocks
    task automatic settle();
        repeat (8) @(negedge ref_clk_in);
    endtask

    task automatic do_reset(input logic por);
        @(negedge ref_clk_in);
        arst_n_in = 1'b0;
        por_n_in = ~por;
        repeat (10) @(negedge ref_clk_in);
        arst_n_in = 1'b1;
        por_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
    endtask

    task automatic rd(input logic [23:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        mask_q.push_back(8'hFF);
        u_host.frame(OP_GENERIC_RD, 24, addr, 0, 8'h00, 1);
        settle();
    endtask

    task automatic wr(input logic [23:0] addr, input logic [7:0] d);
        u_host.frame(OP_GENERIC_WR, 24, addr, 8, d, 0);
        settle();
    endtask

    // outputs follow the live value; quad reads gate the wrap
    task automatic cfg_check(input bwe_cfg_t c);
        for (int q = 0; q < 2; q++) begin
            @(negedge ref_clk_in);
            quad_read_in = q[0];
            @(posedge ref_clk_in);
            #1;
            check("drive", {21'h0, c.drive_strength},
                  {21'h0, live_drive_strength_out});
            check("wrap_len", {22'h0, c.wrap_length},
                  {22'h0, live_wrap_length_out});
            check("wrap_bytes", {17'h0, WRAP_BASE_BYTES << c.wrap_length},
                  {17'h0, wrap_bytes_out});
            check("wrap_active", {23'h0, q[0] & ~c.wrap_disable},
                  {23'h0, wrap_active_out});
        end
        rd(ADDR_LIVE_CFG, c);
    endtask

    initial begin
        arst_n_in = 1'b0;
        por_n_in = 1'b0;
        soft_reset_in = 1'b0;
        quad_read_in = 1'b0;
        ecc_flags_in = 3'h0;
        void'($urandom(18940));
        do_reset(1'b1);
        cfg_check(CFG_FACTORY);
        rd(ADDR_BOOT_CFG, CFG_FACTORY);
        check("status", ECC_RESET, correction_unit_status_out);
        // every wrap length through set-burst-length, wrap enabled
        for (int len = 0; len < 4; len++) begin
            v = {3'($urandom), 1'b0, 2'h0, 2'(len)};
            u_host.frame(OP_SET_BURST, 0, 24'h0, 8, v, 0);
            settle();
            cfg_check(v);
        end
        // generic write, wrap off; reserved bits are kept as written
        v = {3'($urandom), 1'b1, 2'h3, 2'($urandom)};
        wr(ADDR_LIVE_CFG, v);
        cfg_check(v);
        // a frame cut short after five data bits commits nothing
        u_host.frame(OP_SET_BURST, 0, 24'h0, 5, 8'h00, 0);
        settle();
        cfg_check(v);
        rd(24'h000123, RD_UNMAPPED);
        // boot write stays dormant until a reset copy
        b = {3'($urandom), 1'b0, 2'h0, 2'($urandom)};
        wr(ADDR_BOOT_CFG, b);
        cfg_check(v);
        rd(ADDR_BOOT_CFG, b);
        @(negedge ref_clk_in);
        soft_reset_in = 1'b1;
        @(negedge ref_clk_in);
        soft_reset_in = 1'b0;
        settle();
        cfg_check(b);
        // every flag pattern, odd patterns through OP_ECC_RD_B, even through OP_ECC_RD_A
        for (int f = 0; f < 8; f++) begin
            a = 24'($urandom);
            ecc_flags_in = 3'(f);
            addr_q.push_back(a);
            exp_q.push_back({5'h00, 3'(f)});
            // reserved upper status bits are masked off
            mask_q.push_back(8'h07);
            u_host.frame(f[0] ? OP_ECC_RD_B : OP_ECC_RD_A, 24, a, 0, 8'h00,
                         1);
            settle();
            check("status", f[2:0],
                  correction_unit_status_out[2:0]);
        end
        // hardware reset reloads from boot and clears the status
        do_reset(1'b0);
        check("status", {21'h0, 3'h0},
              correction_unit_status_out[2:0]);
        cfg_check(b);
        do_reset(1'b1);
        cfg_check(CFG_FACTORY);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) begin
            @(negedge ref_clk_in);
        end
        if (exp_q.size() > 0 || addr_q.size() > 0) begin
            failures++;
            $display("[ERR] results expected %0d more seen none",
                     exp_q.size() + addr_q.size());
        end
        stop_test();
    end

    // cut a hang short well beyond the normal run length
    initial begin
        #300000;
        failures++;
        $display("[ERR] run_time expected end seen timeout");
        stop_test();
    end
endmodule
